/* File: design/ccr_pkg.sv */
// Package: register map, field layout and encodings of the codec control register bank
package ccr_pkg;
  localparam logic [7:0] ADDR_DAC_CTRL = 8'h02;
  localparam logic [7:0] ADDR_ATT_LEFT = 8'h03;
  localparam logic [7:0] ADDR_ATT_RIGHT = 8'h04;
  localparam logic [7:0] ADDR_PORT_MODE = 8'h05;
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam logic [7:0] ADDR_MCLK_RATIO = 8'h07;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] MUTE_THRESHOLD = 8'he3;
  localparam int DAC_SOFT_BIT = 3;
  localparam int DAC_RATE_LSB = 0;
  localparam int DEEMPH_LSB = 5;
  localparam int EDGE_POL_BIT = 4;
  localparam int OUT_FMT_LSB = 2;
  localparam int IN_FMT_LSB = 0;
  localparam int RIGHT_ACCEPT_BIT = 7;
  localparam int LEFT_ACCEPT_BIT = 6;
  localparam int RIGHT_PEAK_LSB = 3;
  localparam int LEFT_PEAK_LSB = 0;
  localparam logic [6:0] PORT_MODE_MASK = 7'h7f;
  localparam logic [1:0] CLK_RATIO_MASK = 2'h3;
  localparam logic [9:0] ZC_TIMEOUT = 10'h200;
  localparam logic [5:0] STEP_LEN_RATE0 = 6'h08;
  localparam logic [5:0] STEP_LEN_RATE1 = 6'h04;
  localparam logic [5:0] STEP_LEN_RATE2 = 6'h10;
  localparam logic [5:0] STEP_LEN_RATE3 = 6'h20;
  localparam logic [2:0] LEVEL_NORMAL = 3'h0;
  localparam logic [2:0] LEVEL_CLIP = 3'h7;
  typedef enum logic [1:0] {CCR_DEEMPH_44K1, CCR_DEEMPH_48K, CCR_DEEMPH_32K, CCR_DEEMPH_OFF} ccr_deemph_t;
  typedef enum logic [1:0] {CCR_FMT_I2S, CCR_FMT_LJ, CCR_FMT_RJ24, CCR_FMT_RJ20} ccr_format_t;
  typedef enum logic [1:0] {CCR_RATIO_256, CCR_RATIO_384, CCR_RATIO_512, CCR_RATIO_RSV} ccr_mclk_t;
endpackage : ccr_pkg

/* File: design/ccr_chan_if.sv */
// Interface: one channel's attenuation request and progress between bank and ramp unit
`timescale 1ns/1ps
interface ccr_chan_if;
  logic [7:0] target;
  logic load;
  logic [7:0] applied;
  logic mute;
  logic busy;
  modport bank (output target, output load, input applied, input mute, input busy);
  modport unit (input target, input load, output applied, output mute, output busy);
endinterface : ccr_chan_if

/* File: design/ccr_att_ramp.sv */
// Module: per-channel attenuation transition, soft ramp or zero cross
`timescale 1ns/1ps
module ccr_att_ramp (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_sel,
  input wire logic [1:0] rate_sel,
  input wire logic frame_tick,
  input wire logic zero_cross,
  ccr_chan_if.unit ch
);
  logic [7:0] applied_r;
  logic [7:0] target_r;
  logic busy_r;
  logic [5:0] step_cnt_r;
  logic [9:0] tmo_cnt_r;
  logic [5:0] step_len;

  always_comb begin
    case (rate_sel)
      2'h0: step_len = ccr_pkg::STEP_LEN_RATE0;
      2'h1: step_len = ccr_pkg::STEP_LEN_RATE1;
      2'h2: step_len = ccr_pkg::STEP_LEN_RATE2;
      default: step_len = ccr_pkg::STEP_LEN_RATE3;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_r <= 8'h00;
      target_r <= 8'h00;
      busy_r <= 1'b0;
      step_cnt_r <= 6'h00;
      tmo_cnt_r <= 10'h000;
    end else if (ch.load) begin
      target_r <= ch.target;
      busy_r <= (ch.target != applied_r);
      step_cnt_r <= 6'h00;
      tmo_cnt_r <= 10'h000;
    end else if (busy_r && frame_tick) begin
      if (soft_sel) begin
        // Zero cross: single jump, forced after the sample timeout
        if (zero_cross || tmo_cnt_r == ccr_pkg::ZC_TIMEOUT - 10'h001) begin
          applied_r <= target_r;
          busy_r <= 1'b0;
        end else begin
          tmo_cnt_r <= tmo_cnt_r + 10'h001;
        end
      end else if (step_cnt_r == step_len - 6'h01) begin
        // Soft ramp: one half-dB code per step period
        step_cnt_r <= 6'h00;
        if (applied_r < target_r) begin
          applied_r <= applied_r + 8'h01;
          busy_r <= (applied_r + 8'h01 != target_r);
        end else begin
          applied_r <= applied_r - 8'h01;
          busy_r <= (applied_r - 8'h01 != target_r);
        end
      end else begin
        step_cnt_r <= step_cnt_r + 6'h01;
      end
    end
  end

  assign ch.applied = applied_r;
  assign ch.mute = (applied_r > ccr_pkg::MUTE_THRESHOLD);
  assign ch.busy = busy_r;
endmodule : ccr_att_ramp

/* File: design/ccr_control_bank.sv */
// Module: top of the codec control register bank with status and converter controls
`timescale 1ns/1ps
module ccr_control_bank (
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the control port decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic spi_mode,
  // Converter side
  input wire logic master_mode,
  input wire logic frame_tick,
  input wire logic left_zero_cross,
  input wire logic right_zero_cross,
  input wire logic [2:0] left_adc_level,
  input wire logic [2:0] right_adc_level,
  output logic [7:0] left_attenuation_code,
  output logic [7:0] right_attenuation_code,
  output logic left_dac_mute,
  output logic right_dac_mute,
  output logic [1:0] deemphasis_select,
  output logic serial_edge_polarity,
  output logic [1:0] output_frame_format,
  output logic [1:0] input_frame_format,
  output logic [1:0] master_clock_ratio_sel,
  output logic master_clock_ratio_valid
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] dac_ctrl_r;
  logic [7:0] att_left_r;
  logic [7:0] att_right_r;
  logic [6:0] port_mode_r;
  logic [1:0] mclk_ratio_r;
  logic [2:0] left_peak_level_r;
  logic [2:0] right_peak_level_r;
  logic [2:0] left_level_meta_r;
  logic [2:0] left_level_sync_r;
  logic [2:0] right_level_meta_r;
  logic [2:0] right_level_sync_r;
  logic [2:0] ztick_meta_r;
  logic [2:0] ztick_sync_r;
  logic left_setting_accepted;
  logic right_setting_accepted;
  logic status_read;
  logic [7:0] status_word;
  logic [7:0] rdata_nxt;

  ccr_chan_if left_ch ();
  ccr_chan_if right_ch ();

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // One process per register; the status address has no write decode, so writes there vanish
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_ctrl_r <= ccr_pkg::RESET_VALUE;
    end else if (reg_wr && (reg_addr == ccr_pkg::ADDR_DAC_CTRL)) begin
      dac_ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      att_left_r <= ccr_pkg::RESET_VALUE;
    end else if (reg_wr && (reg_addr == ccr_pkg::ADDR_ATT_LEFT)) begin
      att_left_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      att_right_r <= ccr_pkg::RESET_VALUE;
    end else if (reg_wr && (reg_addr == ccr_pkg::ADDR_ATT_RIGHT)) begin
      att_right_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_mode_r <= 7'h00;
    end else if (reg_wr && (reg_addr == ccr_pkg::ADDR_PORT_MODE)) begin
      port_mode_r <= reg_wdata[6:0] & ccr_pkg::PORT_MODE_MASK;
    end
  end

  // Reserved upper bits are dropped, so they always read back as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_ratio_r <= 2'h0;
    end else if (reg_wr && (reg_addr == ccr_pkg::ADDR_MCLK_RATIO)) begin
      mclk_ratio_r <= reg_wdata[1:0] & ccr_pkg::CLK_RATIO_MASK;
    end
  end

  assign left_ch.load = reg_wr && (reg_addr == ccr_pkg::ADDR_ATT_LEFT);
  assign right_ch.load = reg_wr && (reg_addr == ccr_pkg::ADDR_ATT_RIGHT);
  assign left_ch.target = reg_wdata;
  assign right_ch.target = reg_wdata;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Converter pins other than master_mode cross in through two flops before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_level_meta_r <= 3'h0;
      left_level_sync_r <= 3'h0;
    end else begin
      left_level_meta_r <= left_adc_level;
      left_level_sync_r <= left_level_meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      right_level_meta_r <= 3'h0;
      right_level_sync_r <= 3'h0;
    end else begin
      right_level_meta_r <= right_adc_level;
      right_level_sync_r <= right_level_meta_r;
    end
  end

  // Tick and crossings share one delay, so their relative timing is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ztick_meta_r <= 3'h0;
      ztick_sync_r <= 3'h0;
    end else begin
      ztick_meta_r <= {frame_tick, left_zero_cross, right_zero_cross};
      ztick_sync_r <= ztick_meta_r;
    end
  end

  // ----------------------------------------
  // Attenuation transition units
  // ----------------------------------------
  ccr_att_ramp u_left_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .soft_sel(dac_ctrl_r[ccr_pkg::DAC_SOFT_BIT]),
    .rate_sel(dac_ctrl_r[ccr_pkg::DAC_RATE_LSB +: 2]),
    .frame_tick(ztick_sync_r[2]),
    .zero_cross(ztick_sync_r[1]),
    .ch(left_ch.unit)
  );

  ccr_att_ramp u_right_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .soft_sel(dac_ctrl_r[ccr_pkg::DAC_SOFT_BIT]),
    .rate_sel(dac_ctrl_r[ccr_pkg::DAC_RATE_LSB +: 2]),
    .frame_tick(ztick_sync_r[2]),
    .zero_cross(ztick_sync_r[0]),
    .ch(right_ch.unit)
  );

  // Flag is high from the write until the unit reaches the target
  assign left_setting_accepted = left_ch.busy;
  assign right_setting_accepted = right_ch.busy;

  // ----------------------------------------
  // Peak level capture
  // ----------------------------------------
  // Status read only visible under I2C; SPI reads do not exist
  assign status_read = reg_rd && !spi_mode && (reg_addr == ccr_pkg::ADDR_STATUS);

  // A new peak in the read cycle is kept, so no clip event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_peak_level_r <= ccr_pkg::LEVEL_NORMAL;
    end else if (status_read) begin
      left_peak_level_r <= left_level_sync_r;
    end else if (left_level_sync_r > left_peak_level_r) begin
      left_peak_level_r <= left_level_sync_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      right_peak_level_r <= ccr_pkg::LEVEL_NORMAL;
    end else if (status_read) begin
      right_peak_level_r <= right_level_sync_r;
    end else if (right_level_sync_r > right_peak_level_r) begin
      right_peak_level_r <= right_level_sync_r;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    status_word = 8'h00;
    status_word[ccr_pkg::RIGHT_ACCEPT_BIT] = right_setting_accepted;
    status_word[ccr_pkg::LEFT_ACCEPT_BIT] = left_setting_accepted;
    status_word[ccr_pkg::RIGHT_PEAK_LSB +: 3] = right_peak_level_r;
    status_word[ccr_pkg::LEFT_PEAK_LSB +: 3] = left_peak_level_r;
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd && !spi_mode) begin
      case (reg_addr)
        ccr_pkg::ADDR_DAC_CTRL: rdata_nxt = dac_ctrl_r;
        ccr_pkg::ADDR_ATT_LEFT: rdata_nxt = att_left_r;
        ccr_pkg::ADDR_ATT_RIGHT: rdata_nxt = att_right_r;
        ccr_pkg::ADDR_PORT_MODE: rdata_nxt = {1'b0, port_mode_r};
        ccr_pkg::ADDR_STATUS: rdata_nxt = status_word;
        ccr_pkg::ADDR_MCLK_RATIO: rdata_nxt = {6'h00, mclk_ratio_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Converter controls
  // ----------------------------------------
  assign left_attenuation_code = left_ch.applied;
  assign right_attenuation_code = right_ch.applied;
  assign left_dac_mute = left_ch.mute;
  assign right_dac_mute = right_ch.mute;
  assign deemphasis_select = port_mode_r[ccr_pkg::DEEMPH_LSB +: 2];
  assign serial_edge_polarity = port_mode_r[ccr_pkg::EDGE_POL_BIT];
  assign output_frame_format = port_mode_r[ccr_pkg::OUT_FMT_LSB +: 2];
  assign input_frame_format = port_mode_r[ccr_pkg::IN_FMT_LSB +: 2];
  // Ratio only drives clocking in master mode; reads 256 Fs otherwise
  assign master_clock_ratio_sel = master_mode ? mclk_ratio_r : 2'h0;
  assign master_clock_ratio_valid = master_mode && (mclk_ratio_r != 2'h3);
endmodule : ccr_control_bank

/* File: tb/ccr_host_model.sv */
// Host model: register strobes as issued by the control port decoder
`timescale 1ns/1ps
module ccr_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  end
  // Idle lines flip so a stale address or data value is never mistaken for a live one
  task automatic release_bus();
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~reg_addr, ~reg_wdata};
  endtask : release_bus
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b10, a, d};
    @(posedge clk);
    release_bus();
  endtask : write_reg
  // Read data stands until the next read, so it is taken a cycle later at mid-period
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b01, a, reg_wdata};
    @(posedge clk);
    release_bus();
    @(posedge clk);
    @(negedge clk);
    d = reg_rdata;
  endtask : read_reg
endmodule : ccr_host_model

/* File: tb/ccr_control_bank_properties.sv */
// Checker: port-level properties of the control register bank
`timescale 1ns/1ps
module ccr_control_bank_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic spi_mode,
  input wire logic master_mode,
  input wire logic [7:0] left_attenuation_code,
  input wire logic [7:0] right_attenuation_code,
  input wire logic left_dac_mute,
  input wire logic right_dac_mute,
  input wire logic [1:0] deemphasis_select,
  input wire logic serial_edge_polarity,
  input wire logic [1:0] output_frame_format,
  input wire logic [1:0] input_frame_format,
  input wire logic [1:0] master_clock_ratio_sel,
  input wire logic master_clock_ratio_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence port_write_s;
    reg_wr && reg_addr == ccr_pkg::ADDR_PORT_MODE;
  endsequence
  sequence master_write_s;
    master_mode && reg_wr && reg_addr == ccr_pkg::ADDR_MCLK_RATIO ##1 master_mode;
  endsequence
  sequence slave_hold_s;
    !master_mode ##1 !master_mode;
  endsequence
  AST_MUTE_LEFT: assert property (left_dac_mute == (left_attenuation_code > 8'he3))
    else $error("left mute disagrees with applied code");
  AST_MUTE_RIGHT: assert property (right_dac_mute == (right_attenuation_code > 8'he3))
    else $error("right mute disagrees with applied code");
  AST_PORT_WRITE: assert property (port_write_s |=>
    {deemphasis_select, serial_edge_polarity, output_frame_format, input_frame_format} == $past(reg_wdata[6:0]))
    else $error("port mode fields not taken from write");
  AST_RATIO_WRITE: assert property (master_write_s |-> master_clock_ratio_sel == $past(reg_wdata[1:0]))
    else $error("clock ratio not taken from write");
  AST_RATIO_SLAVE: assert property (slave_hold_s |-> master_clock_ratio_sel == 2'h0 && !master_clock_ratio_valid)
    else $error("clock ratio active in slave mode");
  AST_RATIO_VALID: assert property (master_clock_ratio_valid |-> master_clock_ratio_sel != 2'h3)
    else $error("reserved clock ratio flagged valid");
  AST_SPI_READ: assert property (reg_rd && spi_mode |=> reg_rdata == 8'h00)
    else $error("read under spi returned data");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  AST_ATT_RESET: assert property ($rose(rst_n) |-> (left_attenuation_code | right_attenuation_code) == 8'h00)
    else $error("attenuation not zero after reset");
endmodule : ccr_control_bank_properties

bind ccr_control_bank ccr_control_bank_properties ccr_control_bank_properties_inst (.clk(clk), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .spi_mode(spi_mode), .master_mode(master_mode), .left_attenuation_code(left_attenuation_code),
  .right_attenuation_code(right_attenuation_code), .left_dac_mute(left_dac_mute), .right_dac_mute(right_dac_mute),
  .deemphasis_select(deemphasis_select), .serial_edge_polarity(serial_edge_polarity),
  .output_frame_format(output_frame_format), .input_frame_format(input_frame_format),
  .master_clock_ratio_sel(master_clock_ratio_sel), .master_clock_ratio_valid(master_clock_ratio_valid));

/* File: tb/ccr_control_bank_bench.sv */
// Testbench: register access sequences against the control register bank
`timescale 1ns/1ps
module ccr_control_bank_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic spi_mode = 1'b0;
  logic master_mode = 1'b0;
  logic frame_tick = 1'b0;
  logic left_zero_cross = 1'b0;
  logic right_zero_cross = 1'b0;
  logic [2:0] left_adc_level = 3'h0;
  logic [2:0] right_adc_level = 3'h0;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] left_code;
  logic [7:0] right_code;
  logic [7:0] rd;
  logic [7:0] v;
  logic left_mute;
  logic right_mute;
  logic edge_pol;
  logic ratio_valid;
  logic [1:0] deemph;
  logic [1:0] out_fmt;
  logic [1:0] in_fmt;
  logic [1:0] ratio_sel;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  // Sample-rate tick: one cycle in eight
  always @(posedge clk) begin
    cyc <= cyc + 1;
    frame_tick <= (cyc % 8) == 0;
  end
  ccr_control_bank ccr_control_bank_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .spi_mode(spi_mode),
    .master_mode(master_mode), .frame_tick(frame_tick), .left_zero_cross(left_zero_cross),
    .right_zero_cross(right_zero_cross), .left_adc_level(left_adc_level), .right_adc_level(right_adc_level),
    .left_attenuation_code(left_code), .right_attenuation_code(right_code), .left_dac_mute(left_mute),
    .right_dac_mute(right_mute), .deemphasis_select(deemph), .serial_edge_polarity(edge_pol),
    .output_frame_format(out_fmt), .input_frame_format(in_fmt), .master_clock_ratio_sel(ratio_sel),
    .master_clock_ratio_valid(ratio_valid));
  ccr_host_model ccr_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ccr_host_model_inst.write_reg(a, d);
    // Outputs update on the write edge; look at them once settled, mid-cycle
    @(negedge clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    ccr_host_model_inst.read_reg(a, rd);
    check("register read", exp, rd);
  endtask : rd_chk
  // Bounded wait of 3000 cycles for the applied code, short of the 512-tick zero-cross timeout (4096 cycles here)
  task automatic wait_code(input logic right, input logic [7:0] exp);
    for (int i = 0; i < 3000 && (right ? right_code : left_code) !== exp; i++) @(negedge clk);
    check("applied code", exp, right ? right_code : left_code);
  endtask : wait_code
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 3; a < 8; a++) rd_chk(a[7:0], 8'h00);
    @(posedge clk);
    {left_adc_level, right_adc_level} <= {3'h7, 3'h5};
    repeat (3) @(posedge clk);
    {left_adc_level, right_adc_level} <= 6'h00;
    repeat (4) @(posedge clk);
    rd_chk(ccr_pkg::ADDR_STATUS, 8'h2f);
    rd_chk(ccr_pkg::ADDR_STATUS, 8'h00);
    wr(ccr_pkg::ADDR_STATUS, 8'hff);
    rd_chk(ccr_pkg::ADDR_STATUS, 8'h00);
    // Slave mode here; codes 2 and 3 pick right-justified framing, whose 64 Fs serial clock is not modelled
    for (int i = 0; i < 4; i++) begin
      v = {1'b0, i[1:0], i[0], i[1:0], i[1:0]};
      wr(ccr_pkg::ADDR_PORT_MODE, v);
      check("port fields", v, {1'b0, deemph, edge_pol, out_fmt, in_fmt});
      rd_chk(ccr_pkg::ADDR_PORT_MODE, v);
    end
    @(posedge clk) master_mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(ccr_pkg::ADDR_MCLK_RATIO, i[7:0]);
      check("clock ratio", {5'h0, i != 3, i[1:0]}, {5'h0, ratio_valid, ratio_sel});
    end
    @(posedge clk) master_mode <= 1'b0;
    repeat (3) @(negedge clk);
    check("slave ratio", 8'h00, {5'h0, ratio_valid, ratio_sel});
    @(posedge clk) spi_mode <= 1'b1;
    rd_chk(ccr_pkg::ADDR_PORT_MODE, 8'h00);
    @(posedge clk) spi_mode <= 1'b0;
    wr(ccr_pkg::ADDR_DAC_CTRL, 8'h08);
    wr(ccr_pkg::ADDR_ATT_LEFT, 8'he4);
    rd_chk(ccr_pkg::ADDR_STATUS, 8'h40);
    // Crossings stay up a whole frame so that they meet a frame tick
    @(posedge clk) {left_zero_cross, right_zero_cross} <= 2'b11;
    repeat (8) @(posedge clk);
    {left_zero_cross, right_zero_cross} <= 2'b00;
    wait_code(1'b0, 8'he4);
    check("left mute", 8'h01, {7'h0, left_mute});
    rd_chk(ccr_pkg::ADDR_ATT_LEFT, 8'he4);
    rd_chk(ccr_pkg::ADDR_STATUS, 8'h00);
    wr(ccr_pkg::ADDR_ATT_RIGHT, 8'he3);
    @(posedge clk) right_zero_cross <= 1'b1;
    repeat (8) @(posedge clk);
    right_zero_cross <= 1'b0;
    wait_code(1'b1, 8'he3);
    check("right mute", 8'h00, {7'h0, right_mute});
    wr(ccr_pkg::ADDR_DAC_CTRL, 8'h01);
    wr(ccr_pkg::ADDR_ATT_LEFT, 8'he2);
    rd_chk(ccr_pkg::ADDR_STATUS, 8'h40);
    wait_code(1'b0, 8'he3);
    check("left mute", 8'h00, {7'h0, left_mute});
    wait_code(1'b0, 8'he2);
    end_sim();
  end
endmodule : ccr_control_bank_bench
